// File: core/readout_pkg.sv
// Constants for the line and pixel readout addressing block.
// Assumes a 10 MHz pixel clock and a 32-bit classic Wishbone register bus.
package readout_pkg;

	// ------------------------------------------------------------------
	// Array geometry and clock
	// ------------------------------------------------------------------
	localparam int ARRAY_LINES = 1024;
	localparam int ARRAY_COLUMNS = 1024;
	localparam int CLK_PERIOD_NS = 100;

	// ------------------------------------------------------------------
	// Line blanking timing
	// ------------------------------------------------------------------
	localparam int SIGNAL_SAMPLE_NS = 2000;
	localparam int LINE_RESET_NS = 400;
	localparam int REFER_SAMPLE_NS = 2000;
	localparam int SIGNAL_SAMPLE_CYC = (SIGNAL_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINE_RESET_CYC = (LINE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFER_SAMPLE_CYC = (REFER_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Converter
	// ------------------------------------------------------------------
	localparam int ADC_BITS = 12;
	localparam int ADC_LATENCY_PERIODS = 6;
	localparam int CAL_BITS = 16;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] LINE_START_ADDR = 8'h04;
	localparam logic [7:0] COL_START_ADDR = 8'h08;
	localparam logic [7:0] GAIN_ADDR = 8'h0C;
	localparam logic [7:0] LINE_STATUS_ADDR = 8'h10;
	localparam logic [7:0] PIXEL_STATUS_ADDR = 8'h14;
	localparam logic [7:0] ADC_CAL_ADDR = 8'h18;
	localparam logic [7:0] COL_CAL_ADDR = 8'h1C;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_MUX_LSB = 4;
	localparam int GAIN_LSB = 0;
	localparam int OFFSET_LSB = 8;
	localparam int STATUS_VALID_BIT = 10;
	localparam int STATUS_HI_LSB = 16;
	localparam int GAIN_FRAC_BITS = 4;
	localparam logic [7:0] GAIN_RESET = 8'h10;
	localparam logic [7:0] OFFSET_RESET = 8'h00;

	// Output multiplexer sources.
	localparam logic [2:0] MUX_PIXEL = 3'h0;
	localparam logic [2:0] MUX_MONITOR0 = 3'h1;
	localparam logic [2:0] MUX_TEMP = 3'h5;
	localparam int MONITOR_INPUTS = 4;

	typedef enum logic [3:0] {
		BLANK_IDLE = 4'b0001,
		BLANK_SIGNAL = 4'b0010,
		BLANK_RESET = 4'b0100,
		BLANK_REFER = 4'b1000
	} blank_state_t;

endpackage : readout_pkg

// File: core/pointer_if.sv
// Carrier between the readout controller and one one-hot pointer.
// Assumes both ends share the pixel clock.
`timescale 1ns/1ps
interface pointer_if #(
	parameter int LENGTH = 1024,
	parameter int IDX_W = 10
);
	logic init;
	logic advance;
	logic [IDX_W-1:0] start;
	logic [LENGTH-1:0] sel;
	logic [IDX_W-1:0] index;
	logic valid;

	modport ctrl (output init, output advance, output start,
		input sel, input index, input valid);
	modport ptr (input init, input advance, input start,
		output sel, output index, output valid);
endinterface : pointer_if

// File: core/one_hot_pointer.sv
// One-hot shift register pointer with a loadable start position.
// Assumes init and advance are single clock commands from the controller.
`timescale 1ns/1ps
module one_hot_pointer
	import readout_pkg::*;
#(
	parameter int LENGTH = 1024,
	parameter int IDX_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	pointer_if.ptr p
);

	// ------------------------------------------------------------------
	// One bit per line or column
	// ------------------------------------------------------------------
	// Bit 0 is the bottom line or leftmost column, so advancing moves up or right.
	genvar i;
	generate
		for (i = 0; i < LENGTH; i++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					p.sel[i] <= 1'b0;
				end else if (p.init) begin
					p.sel[i] <= (p.start == IDX_W'(i));
				end else if (p.advance) begin
					if (i == 0) begin
						p.sel[i] <= 1'b0;
					end else begin
						p.sel[i] <= p.sel[i-1];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Position tracking
	// ------------------------------------------------------------------
	// Shifting past the last bit leaves the pointer empty until the next init.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p.index <= '0;
			p.valid <= 1'b0;
		end else if (p.init) begin
			p.index <= p.start;
			p.valid <= 1'b1;
		end else if (p.advance && p.valid) begin
			p.index <= p.index + IDX_W'(1);
			p.valid <= (p.index != IDX_W'(LENGTH - 1));
		end
	end

endmodule : one_hot_pointer

// File: core/line_pixel_readout.sv
// Line and pixel addressing, column amplifier sequencing and output chain.
// Assumes the external sequencer drives the pointer commands synchronously
// and that analogue levels arrive already digitised on the level inputs.
//
// Notes on behaviour
// - Two independent one-hot line pointers, one line each.
// - Line pointer init loads the line start position.
// - Each advance command moves a pointer one line.
// - Reset and select act on whole lines only.
// - Read select drives whole line onto columns.
// - One-hot pixel pointer, output left to right.
// - Pixel pointer loads column start, advances one.
// - Lines addressed bottom up, pixels left right.
// - Destructive mode: signal, reset, reference, subtract.
// - Correlated mode bypasses amplifiers, raw level out.
// - Six-input output multiplexer under register control.
// - Gain and offset from a settings register.
// - Settings written by controller over the bus.
// - Converter result appears 6.5 clocks after sampling.
// - Converter calibration arrives over its own serial port.
`timescale 1ns/1ps
module line_pixel_readout
	import readout_pkg::*;
#(
	parameter int LINES = ARRAY_LINES,
	parameter int COLUMNS = ARRAY_COLUMNS,
	parameter int IDX_W = 10,
	parameter int ADC_W = ADC_BITS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic read_line_init_i,
	input wire logic read_line_adv_i,
	input wire logic reset_line_init_i,
	input wire logic reset_line_adv_i,
	input wire logic pixel_init_i,
	input wire logic pixel_adv_i,
	input wire logic blank_start_i,
	input wire logic shutter_reset_i,
	input wire logic [ADC_W-1:0] pixel_signal_i,
	input wire logic [ADC_W-1:0] pixel_reset_i,
	input wire logic [MONITOR_INPUTS*ADC_W-1:0] monitor_i,
	input wire logic [ADC_W-1:0] temp_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	input wire logic spi_cs_n_i,
	output logic [LINES-1:0] line_select_o,
	output logic [LINES-1:0] line_reset_o,
	output logic [COLUMNS-1:0] column_select_o,
	output logic sample_signal_o,
	output logic sample_refer_o,
	output logic amp_bypass_o,
	output logic [CAL_BITS-1:0] col_cal_o,
	output logic [ADC_W-1:0] adc_data_o
);

	// ------------------------------------------------------------------
	// Settings registers
	// ------------------------------------------------------------------
	logic cds_mode;
	logic [2:0] mux_sel;
	logic [IDX_W-1:0] line_start_position;
	logic [IDX_W-1:0] col_start;
	logic [7:0] gain;
	logic [7:0] offset;
	logic [CAL_BITS-1:0] adc_cal;
	logic bus_req;
	logic bus_wr;

	pointer_if #(.LENGTH(LINES), .IDX_W(IDX_W)) read_line_pointer ();
	pointer_if #(.LENGTH(LINES), .IDX_W(IDX_W)) reset_line_pointer ();
	pointer_if #(.LENGTH(COLUMNS), .IDX_W(IDX_W)) pixel_pointer ();

	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_wr = bus_req && we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cds_mode <= 1'b0;
			mux_sel <= MUX_PIXEL;
			line_start_position <= '0;
			col_start <= '0;
			gain <= GAIN_RESET;
			offset <= OFFSET_RESET;
			col_cal_o <= '0;
		end else if (bus_wr) begin
			unique case (adr_i)
				CTRL_ADDR: begin
					if (sel_i[0]) begin
						cds_mode <= dat_i[CTRL_MODE_BIT];
						mux_sel <= dat_i[CTRL_MUX_LSB +: 3];
					end
				end
				LINE_START_ADDR: begin
					if (sel_i[0]) begin
						line_start_position[7:0] <= dat_i[7:0];
					end
					if (sel_i[1]) begin
						line_start_position[IDX_W-1:8] <= dat_i[IDX_W-1:8];
					end
				end
				COL_START_ADDR: begin
					if (sel_i[0]) begin
						col_start[7:0] <= dat_i[7:0];
					end
					if (sel_i[1]) begin
						col_start[IDX_W-1:8] <= dat_i[IDX_W-1:8];
					end
				end
				GAIN_ADDR: begin
					if (sel_i[0]) begin
						gain <= dat_i[GAIN_LSB +: 8];
					end
					if (sel_i[1]) begin
						offset <= dat_i[OFFSET_LSB +: 8];
					end
				end
				COL_CAL_ADDR: begin
					if (sel_i[0]) begin
						col_cal_o[7:0] <= dat_i[7:0];
					end
					if (sel_i[1]) begin
						col_cal_o[15:8] <= dat_i[15:8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------------
	// Every access, mapped or not, is answered one cycle later; unmapped reads give zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= bus_req;
			dat_o <= '0;
			if (bus_req && !we_i) begin
				unique case (adr_i)
					CTRL_ADDR: dat_o <= 32'(cds_mode) | (32'(mux_sel) << CTRL_MUX_LSB);
					LINE_START_ADDR: dat_o <= 32'(line_start_position);
					COL_START_ADDR: dat_o <= 32'(col_start);
					GAIN_ADDR: dat_o <= 32'(gain) | (32'(offset) << OFFSET_LSB);
					LINE_STATUS_ADDR: dat_o <= 32'(read_line_pointer.index)
						| (32'(read_line_pointer.valid) << STATUS_VALID_BIT)
						| (32'(reset_line_pointer.index) << STATUS_HI_LSB)
						| (32'(reset_line_pointer.valid) << (STATUS_HI_LSB + STATUS_VALID_BIT));
					PIXEL_STATUS_ADDR: dat_o <= 32'(pixel_pointer.index)
						| (32'(pixel_pointer.valid) << STATUS_VALID_BIT);
					ADC_CAL_ADDR: dat_o <= 32'(adc_cal);
					COL_CAL_ADDR: dat_o <= 32'(col_cal_o);
					default: dat_o <= '0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Pointers
	// ------------------------------------------------------------------
	// The pixel clock runs at twice the pixel rate, so the column pointer
	// moves on every second edge while advance is held.
	logic pixel_phase;

	always_ff @(posedge clk_i) begin
		if (rst_i || pixel_init_i) begin
			pixel_phase <= 1'b0;
		end else if (pixel_adv_i) begin
			pixel_phase <= !pixel_phase;
		end
	end

	// Two independent line pointers and one column pointer.
	assign read_line_pointer.init = read_line_init_i;
	assign read_line_pointer.advance = read_line_adv_i;
	assign read_line_pointer.start = line_start_position;
	assign reset_line_pointer.init = reset_line_init_i;
	assign reset_line_pointer.advance = reset_line_adv_i;
	assign reset_line_pointer.start = line_start_position;
	assign pixel_pointer.init = pixel_init_i;
	assign pixel_pointer.advance = pixel_adv_i && pixel_phase;
	assign pixel_pointer.start = col_start;

	one_hot_pointer #(.LENGTH(LINES), .IDX_W(IDX_W)) u_read_line (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.p(read_line_pointer)
	);

	one_hot_pointer #(.LENGTH(LINES), .IDX_W(IDX_W)) u_reset_line (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.p(reset_line_pointer)
	);

	one_hot_pointer #(.LENGTH(COLUMNS), .IDX_W(IDX_W)) u_pixel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.p(pixel_pointer)
	);

	// ------------------------------------------------------------------
	// Line blanking sequence
	// ------------------------------------------------------------------
	blank_state_t state;
	logic [7:0] timer;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= BLANK_IDLE;
			timer <= '0;
		end else begin
			unique case (state)
				BLANK_IDLE: begin
					if (blank_start_i) begin
						state <= BLANK_SIGNAL;
						timer <= 8'(SIGNAL_SAMPLE_CYC - 1);
					end
				end
				BLANK_SIGNAL: begin
					if (timer != '0) begin
						timer <= timer - 8'h01;
					end else if (cds_mode) begin
						state <= BLANK_IDLE;
					end else begin
						state <= BLANK_RESET;
						timer <= 8'(LINE_RESET_CYC - 1);
					end
				end
				BLANK_RESET: begin
					if (timer != '0) begin
						timer <= timer - 8'h01;
					end else begin
						state <= BLANK_REFER;
						timer <= 8'(REFER_SAMPLE_CYC - 1);
					end
				end
				BLANK_REFER: begin
					if (timer != '0) begin
						timer <= timer - 8'h01;
					end else begin
						state <= BLANK_IDLE;
					end
				end
			endcase
		end
	end

	// Select and reset drive whole lines; there is no per-pixel reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_select_o <= '0;
			line_reset_o <= '0;
			column_select_o <= '0;
			sample_signal_o <= 1'b0;
			sample_refer_o <= 1'b0;
			amp_bypass_o <= 1'b0;
		end else begin
			if (state == BLANK_IDLE) begin
				line_select_o <= '0;
			end else begin
				line_select_o <= read_line_pointer.sel;
			end
			line_reset_o <= ((state == BLANK_RESET) ? read_line_pointer.sel : '0)
				| (shutter_reset_i ? reset_line_pointer.sel : '0);
			column_select_o <= pixel_pointer.sel;
			sample_signal_o <= (state == BLANK_SIGNAL) && !cds_mode;
			sample_refer_o <= (state == BLANK_REFER);
			amp_bypass_o <= cds_mode;
		end
	end

	// ------------------------------------------------------------------
	// Output multiplexer and gain stage
	// ------------------------------------------------------------------
	logic [ADC_W-1:0] mux_level;
	logic [ADC_W-1:0] pixel_level;
	logic [ADC_W+8:0] scaled;
	logic [ADC_W-1:0] stage_out;

	always_comb begin
		// Destructive mode outputs reference minus signal; a dark pixel reads zero.
		if (cds_mode) begin
			pixel_level = pixel_signal_i;
		end else if (pixel_reset_i > pixel_signal_i) begin
			pixel_level = pixel_reset_i - pixel_signal_i;
		end else begin
			pixel_level = '0;
		end
		mux_level = '0;
		if (mux_sel == MUX_PIXEL) begin
			mux_level = pixel_level;
		end else if (mux_sel == MUX_TEMP) begin
			mux_level = temp_i;
		end else if (mux_sel < MUX_TEMP) begin
			mux_level = monitor_i[(32'(mux_sel) - 32'(MUX_MONITOR0)) * ADC_W +: ADC_W];
		end
		// Gain is fixed point with four fraction bits; the result saturates.
		scaled = ((ADC_W+9)'(mux_level) * (ADC_W+9)'(gain)) >> GAIN_FRAC_BITS;
		scaled = scaled + (ADC_W+9)'(offset);
		if (scaled > (ADC_W+9)'({ADC_W{1'b1}})) begin
			stage_out = {ADC_W{1'b1}};
		end else begin
			stage_out = scaled[ADC_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Converter pipeline
	// ------------------------------------------------------------------
	// A sample taken at rising edge 0 reaches the last stage at edge 6 and
	// is presented at the falling edge that follows, 6.5 clocks in all.
	logic [ADC_W-1:0] pipe [ADC_LATENCY_PERIODS+1];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int k = 0; k <= ADC_LATENCY_PERIODS; k++) begin
				pipe[k] <= '0;
			end
		end else begin
			pipe[0] <= stage_out;
			for (int k = 1; k <= ADC_LATENCY_PERIODS; k++) begin
				pipe[k] <= pipe[k-1];
			end
		end
	end

	always_ff @(negedge clk_i) begin
		if (rst_i) begin
			adc_data_o <= '0;
		end else begin
			adc_data_o <= pipe[ADC_LATENCY_PERIODS];
		end
	end

	// ------------------------------------------------------------------
	// Converter calibration serial port
	// ------------------------------------------------------------------
	// Bits shift in MSB first on rising serial clock; the word is kept when
	// select rises. The serial clock must stay below half the pixel clock.
	logic sclk_q;
	logic cs_n_q;
	logic [CAL_BITS-1:0] cal_shift;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			cal_shift <= '0;
			adc_cal <= '0;
		end else begin
			sclk_q <= spi_sclk_i;
			cs_n_q <= spi_cs_n_i;
			if (!spi_cs_n_i && spi_sclk_i && !sclk_q) begin
				cal_shift <= {cal_shift[CAL_BITS-2:0], spi_mosi_i};
			end
			if (spi_cs_n_i && !cs_n_q) begin
				adc_cal <= cal_shift;
			end
		end
	end

endmodule : line_pixel_readout

// File: tb/pixel_seq_model.sv
// Far-side sequencer model that steps the column pointer across a window.
// Assumes the pixel clock and the block's synchronous active-high reset.
`timescale 1ns/1ps
module pixel_seq_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic stall_i,
	input wire logic [10:0] count_i,
	output logic init_o,
	output logic adv_o,
	output logic done_o
);
	logic [11:0] left;
	logic busy;
	logic started;
	// Two held clocks per pixel, one init first; a stall only delays the start.
	always_ff @(posedge clk_i) begin
		init_o <= 1'b0;
		done_o <= 1'b0;
		if (rst_i) begin
			adv_o <= 1'b0;
			busy <= 1'b0;
			started <= 1'b0;
			left <= 12'h000;
		end else if (go_i && !busy) begin
			busy <= 1'b1;
			left <= {count_i, 1'b0};
		end else if (busy && !(stall_i && !started)) begin
			if (!started) begin
				init_o <= 1'b1;
				started <= 1'b1;
			end else if (left != 12'h000) begin
				adv_o <= 1'b1;
				left <= left - 12'h001;
			end else begin
				adv_o <= 1'b0;
				busy <= 1'b0;
				started <= 1'b0;
				done_o <= 1'b1;
			end
		end
	end
endmodule : pixel_seq_model

// File: tb/readout_monitor.sv
// Port-level checks on the readout block.
// Assumes one pixel clock and the synchronous active-high reset.
`timescale 1ns/1ps
module readout_monitor
	import readout_pkg::*;
#(
	parameter int LINES = 1024,
	parameter int COLUMNS = 1024
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic pixel_init_i,
	input wire logic pixel_adv_i,
	input wire logic shutter_reset_i,
	input wire logic [LINES-1:0] line_select_o,
	input wire logic [LINES-1:0] line_reset_o,
	input wire logic [COLUMNS-1:0] column_select_o,
	input wire logic sample_signal_o,
	input wire logic sample_refer_o,
	input wire logic amp_bypass_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] sig_cnt;
	logic [7:0] ref_cnt;
	// Phase lengths are counted here, as repetitions that long would be slow.
	always_ff @(posedge clk_i) begin
		sig_cnt <= (rst_i || !sample_signal_o) ? 8'h00 : sig_cnt + 8'h01;
	end
	always_ff @(posedge clk_i) begin
		ref_cnt <= (rst_i || !sample_refer_o) ? 8'h00 : ref_cnt + 8'h01;
	end
	sequence s_line_reset;
		(line_reset_o == line_select_o)[*4];
	endsequence
	property p_ack_resp;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack late");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_line_one;
		$onehot0(line_select_o);
	endproperty
	a_line_one: assert property (p_line_one) else $error("line select");
	property p_col_one;
		$onehot0(column_select_o);
	endproperty
	a_col_one: assert property (p_col_one) else $error("column select");
	property p_col_hold;
		!pixel_init_i && !pixel_adv_i |-> ##2 $stable(column_select_o);
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("column moved");
	property p_col_dir;
		pixel_adv_i && !pixel_init_i |-> ##2 (column_select_o == $past(column_select_o))
			|| (column_select_o == ($past(column_select_o) << 1));
	endproperty
	a_col_dir: assert property (p_col_dir) else $error("column step");
	property p_sig_len;
		$fell(sample_signal_o) |-> sig_cnt == 8'(SIGNAL_SAMPLE_CYC);
	endproperty
	a_sig_len: assert property (p_sig_len) else $error("signal length");
	property p_ref_len;
		$fell(sample_refer_o) |-> ref_cnt == 8'(REFER_SAMPLE_CYC);
	endproperty
	a_ref_len: assert property (p_ref_len) else $error("refer length");
	property p_ds_order;
		$fell(sample_signal_o) && !amp_bypass_o && !shutter_reset_i && line_select_o != '0
			|-> s_line_reset ##1 sample_refer_o;
	endproperty
	a_ds_order: assert property (p_ds_order) else $error("reset phase");
	property p_bypass;
		amp_bypass_o |-> !sample_signal_o && !sample_refer_o;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass sampling");
endmodule : readout_monitor
bind line_pixel_readout readout_monitor #(.LINES(LINES), .COLUMNS(COLUMNS)) u_readout_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.pixel_init_i(pixel_init_i), .pixel_adv_i(pixel_adv_i), .shutter_reset_i(shutter_reset_i),
	.line_select_o(line_select_o), .line_reset_o(line_reset_o),
	.column_select_o(column_select_o), .sample_signal_o(sample_signal_o),
	.sample_refer_o(sample_refer_o), .amp_bypass_o(amp_bypass_o));

// File: tb/line_pixel_readout_addressing_tb.sv
// Self-checking bench for the readout block and its sequencer model.
// Assumes a 10 MHz pixel clock and Wishbone classic register access.
`timescale 1ns/1ps
module line_pixel_readout_addressing_tb
	import readout_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic read_line_init_i = 1'b0, read_line_adv_i = 1'b0, reset_line_init_i = 1'b0;
	logic reset_line_adv_i = 1'b0, blank_start_i = 1'b0, shutter_reset_i = 1'b0;
	logic spi_sclk_i = 1'b0, spi_mosi_i = 1'b0, spi_cs_n_i = 1'b1, go = 1'b0, stall = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
	logic [11:0] pixel_signal_i = 12'h100, pixel_reset_i = 12'h300, temp_i = 12'h555, adc_data_o;
	logic [47:0] monitor_i = 48'h4443_3322_2111;
	logic [10:0] count = 11'h003;
	logic [15:0] col_cal_o, cal = 16'h9A5C;
	logic [1023:0] line_select_o, line_reset_o, column_select_o;
	logic ack_o, pixel_init_i, pixel_adv_i, done, sample_signal_o, sample_refer_o, amp_bypass_o;
	logic [11:0] e;
	int num_errors = 0, check_count = 0, cycles = 0, k;
	row_t rows [6] = '{'{LINE_START_ADDR, 32'h0000_03FF, 32'h0000_03FF},
		'{COL_START_ADDR, 32'h0000_0005, 32'h0000_0005}, '{CTRL_ADDR, 32'h0000_0071, 32'h0000_0071},
		'{COL_CAL_ADDR, 32'h0000_ABCD, 32'h0000_ABCD}, '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000},
		'{CTRL_ADDR, 32'h0000_0000, 32'h0000_0000}};
	line_pixel_readout u_line_pixel_readout (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .read_line_init_i(read_line_init_i), .read_line_adv_i(read_line_adv_i),
		.reset_line_init_i(reset_line_init_i), .reset_line_adv_i(reset_line_adv_i),
		.pixel_init_i(pixel_init_i), .pixel_adv_i(pixel_adv_i), .blank_start_i(blank_start_i),
		.shutter_reset_i(shutter_reset_i), .pixel_signal_i(pixel_signal_i),
		.pixel_reset_i(pixel_reset_i), .monitor_i(monitor_i), .temp_i(temp_i),
		.spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i), .spi_cs_n_i(spi_cs_n_i),
		.line_select_o(line_select_o), .line_reset_o(line_reset_o),
		.column_select_o(column_select_o), .sample_signal_o(sample_signal_o),
		.sample_refer_o(sample_refer_o), .amp_bypass_o(amp_bypass_o), .col_cal_o(col_cal_o),
		.adc_data_o(adc_data_o));
	pixel_seq_model u_pixel_seq_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .stall_i(stall),
		.count_i(count), .init_o(pixel_init_i), .adv_o(pixel_adv_i), .done_o(done));
	always #50 clk_i = ~clk_i;
	task automatic end_sim();
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (n >= 50) num_errors++;
	endtask : bus
	// Waits for a sample phase to start, then counts its length in cycles.
	task automatic run_len(input bit refer, output int len);
		int n;
		n = 0;
		len = 0;
		while ((refer ? sample_refer_o : sample_signal_o) !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		while ((refer ? sample_refer_o : sample_signal_o) === 1'b1 && len < 100) begin
			@(negedge clk_i);
			len++;
		end
	endtask : run_len
	task automatic pulse_line(input bit rd_init, input bit rs_init, input int advs);
		@(posedge clk_i);
		{read_line_init_i, reset_line_init_i} <= {rd_init, rs_init};
		@(posedge clk_i);
		{read_line_init_i, reset_line_init_i, read_line_adv_i} <= {2'b00, advs > 0};
		repeat (advs) @(posedge clk_i);
		if (advs > 0) read_line_adv_i <= 1'b0;
	endtask : pulse_line
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, GAIN_ADDR, 32'h0, rd);
		chk("gain reset", rd, 32'h0000_0010);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, rd);
			bus(1'b0, rows[i].a, 32'h0, rd);
			chk("register", rd, rows[i].e);
		end
		chk("col cal pin", {16'h0, col_cal_o}, 32'h0000_ABCD);
		bus(1'b1, LINE_START_ADDR, 32'h0000_0003, rd);
		pulse_line(1'b1, 1'b1, 2);
		bus(1'b0, LINE_STATUS_ADDR, 32'h0, rd);
		chk("line pointers", rd, 32'h0403_0405);
		bus(1'b1, LINE_START_ADDR, 32'h0000_0007, rd);
		pulse_line(1'b0, 1'b1, 0);
		shutter_reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("shutter line", {31'h0, line_reset_o[7]}, 32'h1);
		@(posedge clk_i) shutter_reset_i <= 1'b0;
		@(posedge clk_i) blank_start_i <= 1'b1;
		@(posedge clk_i) blank_start_i <= 1'b0;
		run_len(1'b0, k);
		chk("signal cycles", 32'(k), 32'(SIGNAL_SAMPLE_CYC));
		chk("reset read line", {31'h0, line_reset_o[5]}, 32'h1);
		chk("line driven", {31'h0, line_select_o[5]}, 32'h1);
		run_len(1'b1, k);
		chk("refer cycles", 32'(k), 32'(REFER_SAMPLE_CYC));
		bus(1'b1, CTRL_ADDR, 32'h0000_0001, rd);
		@(posedge clk_i) blank_start_i <= 1'b1;
		@(posedge clk_i) blank_start_i <= 1'b0;
		run_len(1'b0, k);
		chk("bypass", {31'h0, amp_bypass_o}, 32'h1);
		chk("bypass sampling", 32'(k), 32'h0);
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, CTRL_ADDR, 32'(m) << CTRL_MUX_LSB, rd);
			repeat (10) @(posedge clk_i);
			e = (m == 0) ? 12'h200 : (m < 5) ? monitor_i[(m-1)*12 +: 12] : (m == 5) ? temp_i : 12'h0;
			chk("mux source", {20'h0, adc_data_o}, {20'h0, e});
		end
		bus(1'b1, CTRL_ADDR, 32'h0000_0050, rd);
		bus(1'b1, GAIN_ADDR, 32'h0000_0320, rd);
		temp_i <= 12'h100;
		repeat (10) @(posedge clk_i);
		chk("gain offset", {20'h0, adc_data_o}, 32'h0000_0203);
		temp_i <= 12'hC00;
		repeat (10) @(posedge clk_i);
		chk("saturation", {20'h0, adc_data_o}, 32'h0000_0FFF);
		bus(1'b1, GAIN_ADDR, 32'h0000_0010, rd);
		repeat (10) @(posedge clk_i);
		temp_i <= 12'h7A1;
		repeat (7) @(posedge clk_i);
		chk("converter old", {20'h0, adc_data_o}, 32'h0000_0C00);
		@(posedge clk_i);
		chk("converter new", {20'h0, adc_data_o}, 32'h0000_07A1);
		{go, stall} <= 2'b11;
		@(posedge clk_i) go <= 1'b0;
		repeat (3) @(posedge clk_i);
		stall <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 100) begin
			@(negedge clk_i);
			k++;
		end
		bus(1'b0, PIXEL_STATUS_ADDR, 32'h0, rd);
		chk("column pointer", rd, 32'h0000_0408);
		chk("column pin", {31'h0, column_select_o[8]}, 32'h1);
		spi_cs_n_i <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge clk_i) spi_mosi_i <= cal[i];
			repeat (2) @(posedge clk_i);
			spi_sclk_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			spi_sclk_i <= 1'b0;
		end
		repeat (2) @(posedge clk_i);
		spi_cs_n_i <= 1'b1;
		bus(1'b0, ADC_CAL_ADDR, 32'h0, rd);
		chk("calibration", rd, 32'h0000_9A5C);
		bus(1'b1, LINE_START_ADDR, 32'h0000_03FF, rd);
		pulse_line(1'b1, 1'b0, 0);
		bus(1'b0, LINE_STATUS_ADDR, 32'h0, rd);
		chk("last line", rd, 32'h0407_07FF);
		pulse_line(1'b0, 1'b0, 1);
		bus(1'b0, LINE_STATUS_ADDR, 32'h0, rd);
		chk("past end", rd, 32'h0407_0000);
		end_sim();
	end
endmodule : line_pixel_readout_addressing_tb
